// File: rtl/pipe_seq.sv
// Pipeline sequencer: stage flow, load-use and multiplier interlocks
`include "pipe_seq_defines.svh"
module pipe_seq
  import pipe_seq_pkg::*;
#(
  parameter int PC_W = `PC_W_DEF,
  parameter int REG_W = `REG_IDX_W_DEF,
  parameter int BUSY_CYCLES = `MUL_BUSY_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Instruction word found at fetch_pc
  input wire op_class_t inst_class,
  input wire logic [REG_W-1:0] inst_dst,
  input wire logic [REG_W-1:0] inst_src_a,
  input wire logic [REG_W-1:0] inst_src_b,
  input wire logic [1:0] inst_src_use,
  // Fetch address
  output logic [PC_W-1:0] fetch_pc,
  // Bus and multiplier report, one cycle late except mul_busy, which is the live countdown flag
  output logic bus_ma,
  output logic bus_if,
  output logic bus_split,
  output logic mul_operand,
  output logic mul_stretch,
  output logic mul_busy,
  // Stage occupancy
  output logic id_valid,
  output logic ex_valid,
  output logic ma_valid,
  output logic wb_valid,
  output logic [REG_W-1:0] wb_dst,
  // Execute results and stalls
  output logic alu_done,
  output logic [REG_W-1:0] alu_dst,
  output logic decode_stall
);
  localparam op_class_t OP_MACW = OP_MULTIPLY_ACCUMULATE_WORD;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic id_v;
    op_class_t id_cls;
    logic [REG_W-1:0] id_dst;
    logic [REG_W-1:0] id_sa;
    logic [REG_W-1:0] id_sb;
    logic [1:0] id_use;
    logic ex_v;
    op_class_t ex_cls;
    logic [REG_W-1:0] ex_dst;
    logic ma_v;
    op_class_t ma_cls;
    logic [REG_W-1:0] ma_dst;
    logic ma_second;
    logic wb_v;
    logic [REG_W-1:0] wb_dst;
    logic rep_ma;
    logic rep_if;
    logic rep_split;
    logic rep_operand;
    logic rep_stretch;
    logic rep_stall;
    logic rep_alu;
    logic [REG_W-1:0] rep_alu_dst;
  } seq_state_t;

  seq_state_t s_reg;
  seq_state_t s_next;

  logic ma_hold;
  logic ma_mul;
  logic ex_to_ma;
  logic load_use;
  logic mac_follow;
  logic id_stall;
  logic if_req;
  logic ma_req;
  logic mul_wait;
  logic busy_load;
  logic busy_w;
  logic ma_gnt;
  logic if_gnt;
  logic slot_done;

  if (PC_W < 2 || REG_W < 1) begin : g_chk
    $error("PC_W must be at least 2 and REG_W at least 1");
  end

  // ******************************************************************
  // Class decoding
  // ******************************************************************
  function automatic logic needs_ma(input op_class_t c);
    return c inside {OP_LOAD, OP_STORE, OP_MACW, OP_SIGNED_MULTIPLY_WORD,
      OP_MOVE_FROM_RESULT_REG, OP_STORE_RESULT_REG_TO_MEMORY,
      OP_MOVE_TO_RESULT_REG, OP_LOAD_RESULT_REG_FROM_MEMORY};
  endfunction

  function automatic logic uses_bus(input op_class_t c);
    return c inside {OP_LOAD, OP_STORE, OP_MACW,
      OP_STORE_RESULT_REG_TO_MEMORY, OP_LOAD_RESULT_REG_FROM_MEMORY};
  endfunction

  function automatic logic uses_mul(input op_class_t c);
    return c inside {OP_MACW, OP_SIGNED_MULTIPLY_WORD,
      OP_MOVE_FROM_RESULT_REG, OP_STORE_RESULT_REG_TO_MEMORY,
      OP_MOVE_TO_RESULT_REG, OP_LOAD_RESULT_REG_FROM_MEMORY};
  endfunction

  function automatic logic writes_gpr(input op_class_t c);
    return c inside {OP_LOAD, OP_MOVE_FROM_RESULT_REG};
  endfunction

  function automatic logic src_hit(input logic [1:0] use_v,
      input logic [REG_W-1:0] sa, input logic [REG_W-1:0] sb,
      input logic [REG_W-1:0] dst);
    return (use_v[0] && sa == dst) || (use_v[1] && sb == dst);
  endfunction

  // ******************************************************************
  // Helpers
  // ******************************************************************
  mem_slot_arbiter u_arb (
    .core_clk(core_clk),
    .rstn(rstn),
    .ma_req(ma_req),
    .if_req(if_req),
    .mul_wait(mul_wait),
    .ma_gnt(ma_gnt),
    .if_gnt(if_gnt),
    .slot_done(slot_done)
  );

  mul_busy_counter #(
    .BUSY_CYCLES(BUSY_CYCLES)
  ) u_busy (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(busy_load),
    .busy(busy_w)
  );

  // ******************************************************************
  // Interlocks
  // ******************************************************************
  always_comb begin
    // Mul-acc keeps the access stage for a second slot
    ma_hold = s_reg.ma_v && s_reg.ma_cls == OP_MACW &&
      !s_reg.ma_second;
    // Only the second mul-acc access talks to the multiplier
    ma_mul = s_reg.ma_v && uses_mul(s_reg.ma_cls) &&
      (s_reg.ma_cls != OP_MACW || s_reg.ma_second);
    ex_to_ma = s_reg.ex_v && needs_ma(s_reg.ex_cls);
    load_use = s_reg.ex_v && s_reg.ex_cls == OP_LOAD &&
      src_hit(s_reg.id_use, s_reg.id_sa, s_reg.id_sb,
      s_reg.ex_dst);
    // Whatever follows, one slot of decode hold is enough
    mac_follow = s_reg.ex_v && s_reg.ex_cls == OP_MACW;
    id_stall = s_reg.id_v && (load_use || mac_follow);
    if_req = !id_stall;
    ma_req = s_reg.ma_v && uses_bus(s_reg.ma_cls);
    // Gate only while the countdown runs; an idle one costs nothing
    mul_wait = ma_mul && busy_w;
    busy_load = slot_done && s_reg.ma_v &&
      ((s_reg.ma_cls == OP_MACW && s_reg.ma_second) ||
      s_reg.ma_cls == OP_SIGNED_MULTIPLY_WORD);
  end

  // ******************************************************************
  // Stage advance
  // ******************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.rep_ma = ma_gnt;
    s_next.rep_if = if_gnt;
    s_next.rep_split = ma_gnt && !slot_done;
    s_next.rep_operand = ma_gnt && s_reg.ma_cls == OP_MACW &&
      s_reg.ma_second;
    s_next.rep_stretch = mul_wait;
    s_next.rep_stall = slot_done && id_stall;
    s_next.rep_alu = slot_done && s_reg.ex_v &&
      s_reg.ex_cls == OP_ALU;
    s_next.rep_alu_dst = s_reg.ex_dst;
    if (if_gnt) begin
      s_next.pc = s_reg.pc + 1'b1;
    end
    if (slot_done) begin
      // Only loads and moves from the result register return data to a register
      s_next.wb_v = s_reg.ma_v && !ma_hold &&
        writes_gpr(s_reg.ma_cls);
      s_next.wb_dst = s_reg.ma_dst;
      if (ma_hold) begin
        s_next.ma_second = 1'b1;
      end else begin
        // ALU operations never enter the access stage
        s_next.ma_v = ex_to_ma;
        s_next.ma_cls = s_reg.ex_cls;
        s_next.ma_dst = s_reg.ex_dst;
        s_next.ma_second = 1'b0;
      end
      s_next.ex_v = s_reg.id_v && !id_stall;
      s_next.ex_cls = s_reg.id_cls;
      s_next.ex_dst = s_reg.id_dst;
      if (if_gnt) begin
        s_next.id_v = (inst_class != OP_NONE);
        s_next.id_cls = inst_class;
        s_next.id_dst = inst_dst;
        s_next.id_sa = inst_src_a;
        s_next.id_sb = inst_src_b;
        s_next.id_use = inst_src_use;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign fetch_pc = s_reg.pc;
  assign bus_ma = s_reg.rep_ma;
  assign bus_if = s_reg.rep_if;
  assign bus_split = s_reg.rep_split;
  assign mul_operand = s_reg.rep_operand;
  assign mul_stretch = s_reg.rep_stretch;
  assign mul_busy = busy_w;
  assign id_valid = s_reg.id_v;
  assign ex_valid = s_reg.ex_v;
  assign ma_valid = s_reg.ma_v;
  assign wb_valid = s_reg.wb_v;
  assign wb_dst = s_reg.wb_dst;
  assign alu_done = s_reg.rep_alu;
  assign alu_dst = s_reg.rep_alu_dst;
  assign decode_stall = s_reg.rep_stall;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_load_wb;
    slot_done && s_reg.ma_v && s_reg.ma_cls == OP_LOAD
      |=> s_reg.wb_v && s_reg.wb_dst == $past(s_reg.ma_dst);
  endproperty
  a_load_wb: assert property (p_load_wb)
    else $error("load left access stage without write-back");

  property p_load_use;
    slot_done && s_reg.id_v && load_use |=> !s_reg.ex_v ##0 s_reg.id_v;
  endproperty
  a_load_use: assert property (p_load_use)
    else $error("load-use follower was not held in decode");

  property p_store_no_wb;
    slot_done && s_reg.ma_v && s_reg.ma_cls == OP_STORE |=> !s_reg.wb_v;
  endproperty
  a_store_no_wb: assert property (p_store_no_wb)
    else $error("store produced a write-back");

  property p_alu_ex;
    slot_done && s_reg.ex_v && s_reg.ex_cls == OP_ALU
      |=> alu_done && !s_reg.ma_v;
  endproperty
  a_alu_ex: assert property (p_alu_ex)
    else $error("ALU operation did not finish in execute");

  property p_mac_two_ma;
    slot_done && ma_hold
      |=> s_reg.ma_v && s_reg.ma_second && s_reg.ma_cls == OP_MACW;
  endproperty
  a_mac_two_ma: assert property (p_mac_two_ma)
    else $error("mul-acc lost its second access");

  property p_operand;
    mul_operand |-> $past(s_reg.ma_second) && bus_ma;
  endproperty
  a_operand: assert property (p_operand)
    else $error("operand handed over outside second access");

  property p_busy_len;
    busy_load |=> mul_busy [*2] ##1 (!mul_busy || $past(busy_load));
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("multiplier busy not exactly two cycles");

  property p_mac_follow;
    slot_done && mac_follow && s_reg.id_v |=> !s_reg.ex_v && s_reg.id_v;
  endproperty
  a_mac_follow: assert property (p_mac_follow)
    else $error("decode after mul-acc not held");

  property p_split;
    ma_req && if_req && !mul_wait && !bus_split |=> bus_ma ##1 bus_if;
  endproperty
  a_split: assert property (p_split)
    else $error("colliding access and fetch did not split");

  property p_stretch;
    mul_wait |-> !slot_done && !ma_gnt && !if_gnt;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("access proceeded while multiplier busy");

  // Idle countdown must never hold the access back
  property p_idle_gate;
    ma_mul && !busy_w |-> ma_gnt || slot_done;
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("access held with multiplier idle");

  c_stretch: cover property (mul_stretch ##1 !mul_stretch);
  c_split: cover property (bus_split ##1 bus_if);
  c_operand: cover property (mul_operand);
  c_load_use: cover property (slot_done && load_use);

endmodule

// File: include/pipe_seq_defines.svh
// Constants shared by the pipeline sequencer and its helpers
`ifndef PIPE_SEQ_DEFINES_SVH
`define PIPE_SEQ_DEFINES_SVH

// ********************************************************************
// Timing
// ********************************************************************
`define MUL_BUSY_CYCLES 2

// ********************************************************************
// Widths and reset values
// ********************************************************************
`define PC_W_DEF 16
`define REG_IDX_W_DEF 4
`define SLOT_RESET_ST 2'h0

`endif

// File: include/pipe_seq_pkg.sv
// Types shared by the pipeline sequencer and its helpers
package pipe_seq_pkg;

  // ******************************************************************
  // Instruction classes
  // ******************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ALU = 4'h1,
    OP_LOAD = 4'h2,
    OP_STORE = 4'h3,
    OP_MULTIPLY_ACCUMULATE_WORD = 4'h4,
    OP_SIGNED_MULTIPLY_WORD = 4'h5,
    OP_MOVE_FROM_RESULT_REG = 4'h6,
    OP_STORE_RESULT_REG_TO_MEMORY = 4'h7,
    OP_MOVE_TO_RESULT_REG = 4'h8,
    OP_LOAD_RESULT_REG_FROM_MEMORY = 4'h9
  } op_class_t;

  // ******************************************************************
  // Slot phases, Gray along run, split, stretch
  // ******************************************************************
  typedef enum logic [1:0] {
    SLOT_RUN = 2'h0,
    SLOT_SPLIT = 2'h1,
    SLOT_STRETCH = 2'h3
  } slot_state_t;

endpackage

// File: rtl/mul_busy_counter.sv
// Multiplier busy countdown, free of slot boundaries
`include "pipe_seq_defines.svh"
module mul_busy_counter
  import pipe_seq_pkg::*;
#(
  parameter int BUSY_CYCLES = `MUL_BUSY_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Load at end of last multiplier access
  input wire logic load,
  // Busy flag
  output logic busy
);
  localparam int CNT_W = $clog2(BUSY_CYCLES + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  if (BUSY_CYCLES < 1) begin : g_chk
    $error("BUSY_CYCLES must be at least one");
  end

  // ******************************************************************
  // Countdown
  // ******************************************************************
  // Counts cycles, not slots, so a split slot does not lengthen it
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.cnt = CNT_W'(BUSY_CYCLES);
    end else if (state_reg.cnt != '0) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
    state_next.busy = (state_next.cnt != '0);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;

endmodule

// File: rtl/mem_slot_arbiter.sv
// Memory bus slot arbiter: access first, fetch second on collision
`include "pipe_seq_defines.svh"
module mem_slot_arbiter
  import pipe_seq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Requests
  input wire logic ma_req,
  input wire logic if_req,
  input wire logic mul_wait,
  // Grants
  output logic ma_gnt,
  output logic if_gnt,
  output logic slot_done
);
  typedef struct packed {
    slot_state_t st;
  } arb_state_t;

  arb_state_t state_reg;
  arb_state_t state_next;

  // ******************************************************************
  // Slot sequencing
  // ******************************************************************
  always_comb begin
    state_next = state_reg;
    ma_gnt = 1'b0;
    if_gnt = 1'b0;
    slot_done = 1'b0;
    case (state_reg.st)
      SLOT_RUN, SLOT_STRETCH: begin
        if (mul_wait) begin
          // Bus stays idle; the slot simply grows
          state_next.st = SLOT_STRETCH;
        end else if (ma_req && if_req) begin
          ma_gnt = 1'b1;
          state_next.st = SLOT_SPLIT;
        end else begin
          ma_gnt = ma_req;
          if_gnt = if_req;
          slot_done = 1'b1;
          state_next.st = SLOT_RUN;
        end
      end
      SLOT_SPLIT: begin
        if_gnt = 1'b1;
        slot_done = 1'b1;
        state_next.st = SLOT_RUN;
      end
      default: begin
        state_next.st = SLOT_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.st <= slot_state_t'(`SLOT_RESET_ST);
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// File: verif/testbench.sv
// Self-checking bench for the pipeline sequencer
module testbench
  import pipe_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ******************************************************************
  // Clock, reset and design ports
  // ******************************************************************
  localparam int TIMEOUT_CYCLES = 2000;
  logic core_clk;
  logic rstn;
  op_class_t inst_class;
  logic [3:0] inst_dst, inst_src_a, inst_src_b;
  logic [1:0] inst_src_use;
  logic [15:0] fetch_pc;
  logic bus_ma, bus_if, bus_split, mul_operand, mul_stretch, mul_busy;
  logic id_valid, ex_valid, ma_valid, wb_valid, alu_done, decode_stall;
  logic [3:0] wb_dst, alu_dst;
  int fail_count = 0;
  int checked = 0;
  int cyc, tcycles;
  op_class_t p_cls [16];
  logic [3:0] p_dst [16];
  logic [3:0] p_sa [16];
  logic [1:0] p_use [16];
  int n_alu, n_ma, n_split, n_opnd, n_stretch, n_stall, n_wb;
  int busy_run, busy_max, busy_runs, first_alu;
  bit seen_stretch, split_after_stretch;
  logic [3:0] first_dst, wb_last;

  pipe_seq pipe_seq_i (.core_clk(core_clk), .rstn(rstn),
    .inst_class(inst_class), .inst_dst(inst_dst),
    .inst_src_a(inst_src_a), .inst_src_b(inst_src_b),
    .inst_src_use(inst_src_use), .fetch_pc(fetch_pc),
    .bus_ma(bus_ma), .bus_if(bus_if), .bus_split(bus_split),
    .mul_operand(mul_operand), .mul_stretch(mul_stretch),
    .mul_busy(mul_busy), .id_valid(id_valid), .ex_valid(ex_valid),
    .ma_valid(ma_valid), .wb_valid(wb_valid), .wb_dst(wb_dst),
    .alu_done(alu_done), .alu_dst(alu_dst),
    .decode_stall(decode_stall));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ******************************************************************
  // Instruction memory, presented just after each edge
  // ******************************************************************
  function automatic int pc_idx();
    return (fetch_pc < 16'h0010) ? int'(fetch_pc) : 15;
  endfunction

  always @(posedge core_clk) begin
    #1;
    inst_class <= p_cls[pc_idx()];
    inst_dst <= p_dst[pc_idx()];
    inst_src_a <= p_sa[pc_idx()];
    inst_src_b <= 4'hF;
    inst_src_use <= p_use[pc_idx()];
  end

  // ******************************************************************
  // Event monitor, sampled mid-cycle where outputs are settled
  // ******************************************************************
  always @(posedge core_clk) begin
    cyc <= rstn ? cyc + 1 : 0;
    tcycles <= tcycles + 1;
    if (tcycles >= TIMEOUT_CYCLES) begin
      fail_count++;
      give_verdict();
    end
  end

  always @(negedge core_clk) begin
    if (rstn === 1'b1) begin
      if (alu_done === 1'b1) begin
        n_alu++;
        if (first_alu < 0) begin
          first_alu = cyc;
          first_dst = alu_dst;
        end
      end
      if (bus_ma === 1'b1) n_ma++;
      if (bus_split === 1'b1) begin
        n_split++;
        if (seen_stretch) split_after_stretch = 1'b1;
      end
      if (mul_operand === 1'b1) n_opnd++;
      if (mul_stretch === 1'b1) begin
        n_stretch++;
        seen_stretch = 1'b1;
      end
      if (decode_stall === 1'b1) n_stall++;
      if (wb_valid === 1'b1) begin
        n_wb++;
        wb_last = wb_dst;
      end
      if (mul_busy === 1'b1) busy_run++;
      else if (busy_run > 0) begin
        busy_runs++;
        if (busy_run > busy_max) busy_max = busy_run;
        busy_run = 0;
      end
    end
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic clear_prog();
    for (int i = 0; i < 16; i++) begin
      p_cls[i] = OP_NONE;
      p_dst[i] = 4'h0;
      p_sa[i] = 4'h0;
      p_use[i] = 2'h0;
    end
  endtask

  task automatic put(input int i, input op_class_t c, input logic [3:0] d,
                     input logic [3:0] sa, input logic [1:0] u);
    p_cls[i] = c;
    p_dst[i] = d;
    p_sa[i] = sa;
    p_use[i] = u;
  endtask

  // Fresh reset per program so counts start clean
  task automatic run();
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (5) @(posedge core_clk);
    {n_alu, n_ma, n_split, n_opnd, n_stretch, n_stall, n_wb} = '0;
    {busy_run, busy_max, busy_runs} = '0;
    first_alu = -1;
    seen_stretch = 1'b0;
    split_after_stretch = 1'b0;
    #1 rstn = 1'b1;
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_alu();
    clear_prog();
    for (int i = 0; i < 4; i++) put(i, OP_ALU, 4'(i + 1), 4'h0, 2'h0);
    run();
    // First edge takes the word, the third reports the result
    chk(first_alu == 3, "alu result late or early");
    chk(fetch_pc === 16'h0028 && bus_if === 1'b1, "fetch stream");
    chk(first_dst === 4'h1, "alu destination wrong");
    chk(n_alu == 4 && n_ma == 0 && n_wb == 0, "alu stream");
    chk(n_stall == 0, "alu stream stalled");
  endtask

  task automatic t_load(input logic [3:0] src, input int stalls);
    clear_prog();
    put(0, OP_LOAD, 4'h5, 4'h0, 2'h0);
    put(1, OP_ALU, 4'h2, src, 2'h1);
    run();
    chk(n_stall == stalls, "load follower stall count");
    chk(n_wb >= 1 && wb_last === 4'h5, "load write-back");
    chk(n_ma == 1 && n_alu == 1, "load access count");
    chk({id_valid, ex_valid, ma_valid, wb_valid} === 4'h0,
        "pipeline not drained");
  endtask

  task automatic t_store();
    clear_prog();
    put(0, OP_STORE, 4'h7, 4'h0, 2'h0);
    put(1, OP_ALU, 4'h3, 4'h0, 2'h0);
    run();
    chk(n_wb == 0, "store wrote back");
    chk(n_ma == 1 && n_alu == 1, "store access count");
  endtask

  task automatic t_mac();
    clear_prog();
    put(0, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h1, 2'h3);
    put(1, OP_ALU, 4'h4, 4'h0, 2'h0);
    run();
    chk(n_ma == 2 && n_wb == 0, "mul-acc stages");
    chk(n_opnd == 1, "operand handed over");
    chk(busy_runs == 1 && busy_max == 2, "busy length");
    chk(n_stall == 1, "follower decode hold");
    chk(n_alu == 1 && n_stretch == 0, "plain follower");
    chk(n_split >= 1, "access and fetch split");
  endtask

  task automatic t_gap();
    clear_prog();
    put(0, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h1, 2'h3);
    put(1, OP_ALU, 4'h4, 4'h0, 2'h0);
    put(2, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h2, 2'h3);
    run();
    chk(n_stretch == 0, "stretch despite gap");
    chk(n_opnd == 2 && n_ma == 4, "two mul-accs");
  endtask

  task automatic t_macmac();
    clear_prog();
    put(0, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h1, 2'h3);
    put(1, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h2, 2'h3);
    put(2, OP_ALU, 4'h4, 4'h0, 2'h0);
    run();
    chk(n_opnd == 2 && n_ma == 4, "back-to-back mul-acc");
    chk(n_stretch == 0 && busy_max == 2, "stretch after misalign");
  endtask

  // Every multiplier user other than mul-acc straight after a mul-acc
  task automatic t_users();
    op_class_t users [5];
    int want_wb;
    users = '{OP_SIGNED_MULTIPLY_WORD, OP_MOVE_FROM_RESULT_REG,
              OP_STORE_RESULT_REG_TO_MEMORY, OP_MOVE_TO_RESULT_REG,
              OP_LOAD_RESULT_REG_FROM_MEMORY};
    foreach (users[k]) begin
      clear_prog();
      put(0, OP_MULTIPLY_ACCUMULATE_WORD, 4'h0, 4'h1, 2'h3);
      put(1, users[k], 4'h6, 4'h0, 2'h0);
      put(2, OP_ALU, 4'h4, 4'h0, 2'h0);
      run();
      chk(n_stretch >= 1, "no contention stretch");
      chk(n_stretch <= 2, "stretch beyond busy");
      want_wb = (users[k] == OP_MOVE_FROM_RESULT_REG) ? 1 : 0;
      chk(n_wb == want_wb, "result move write-back");
      if (users[k] == OP_STORE_RESULT_REG_TO_MEMORY ||
          users[k] == OP_LOAD_RESULT_REG_FROM_MEMORY) begin
        chk(split_after_stretch, "stretched access unsplit");
      end
    end
  endtask

  // ******************************************************************
  // Verdict and main sequence
  // ******************************************************************
  task automatic give_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    cyc = 0;
    tcycles = 0;
    clear_prog();
    inst_class = OP_NONE;
    inst_dst = 4'h0;
    inst_src_a = 4'h0;
    inst_src_b = 4'hF;
    inst_src_use = 2'h0;
    t_alu();
    t_load(4'h5, 1);
    t_load(4'h6, 0);
    t_store();
    t_mac();
    t_gap();
    t_macmac();
    t_users();
    give_verdict();
  end
endmodule
